// ---- shared/thermal_feature_pkg.sv ----
// Shared constants and carrier types for the thermal and feature register bank.
package thermal_feature_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 64;

  // Register indices, one 64-bit register per index.
  localparam logic [ADDR_W-1:0] OFS_PERF_STATE_REQUEST  = 12'h199;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_DUTY_THROTTLE = 12'h19a;
  localparam logic [ADDR_W-1:0] OFS_THERMAL_IRQ_CTRL    = 12'h19b;
  localparam logic [ADDR_W-1:0] OFS_THERMAL_MON_STATE   = 12'h19c;
  localparam logic [ADDR_W-1:0] OFS_SECOND_STAGE_TARGET = 12'h19d;
  localparam logic [ADDR_W-1:0] OFS_MISC_FEATURE_SW     = 12'h1a0;
  localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS        = 12'h1f0;
  localparam logic [ADDR_W-1:0] OFS_EVENT_ENABLE        = 12'h1f1;
  localparam logic [ADDR_W-1:0] OFS_EVENT_CLEAR         = 12'h1f2;

  // Plain storage registers, kept as one indexed array.
  localparam int PLAIN_N = 4;
  localparam int PLAIN_W = 2;

  // Misc feature switch fields.
  localparam int SPLIT_LOCK_DISABLE_BIT = 4;
  localparam int RSVD_BIT_A             = 1;
  localparam int RSVD_BIT_B             = 5;
  localparam logic [DATA_W-1:0] MISC_WRITE_MASK = 64'hffff_ffff_ffff_ffdd;

  // Reset values.
  localparam logic [DATA_W-1:0] PLAIN_RESET  = 64'h0;
  localparam logic [DATA_W-1:0] TARGET_RESET = 64'h0;
  localparam logic [DATA_W-1:0] MISC_RESET   = 64'h0;

  // Event status bits.
  localparam int EV_ALIGN_FAULT = 0;
  localparam int EV_GP_FAULT    = 1;
  localparam int EV_SPLIT_LOCK  = 2;
  localparam int EV_TARGET_LOAD = 3;
  localparam int EV_W           = 4;
  localparam logic [EV_W-1:0] EV_RESET = 4'h0;

  // Processor model variants of the second-stage target register.
  localparam int MODEL_LOADS_TARGET = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic req;
    logic split;
  } lock_req_t;

  typedef struct packed {
    logic align_fault;
    logic split_cycle;
    logic plain_cycle;
  } lock_ans_t;

endpackage

// ---- verilog/thermal_feature_regs.sv ----
// Thermal control, performance request and feature switch register bank.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns

module thermal_feature_regs
  import thermal_feature_pkg::*;
#(
  parameter int MODEL = 3
)
(
  input  wire logic                           CLK,
  input  wire logic                           RESET,
  input  wire thermal_feature_pkg::reg_req_t  BUS_REQ,
  output logic [thermal_feature_pkg::DATA_W-1:0] RDATA,
  output logic                                GP_FAULT,
  input  wire thermal_feature_pkg::lock_req_t LOCK_IN,
  output thermal_feature_pkg::lock_ans_t      LOCK_OUT,
  output logic [thermal_feature_pkg::DATA_W-1:0] THROTTLE_TARGET,
  output logic [thermal_feature_pkg::DATA_W-1:0] FEATURE_SWITCHES,
  output logic                                IRQ
);

  import thermal_feature_pkg::*;

  logic [DATA_W-1:0]  plain_reg [PLAIN_N];
  logic [DATA_W-1:0]  target;
  logic [DATA_W-1:0]  misc;
  logic [EV_W-1:0]    ev_status;
  logic [EV_W-1:0]    ev_enable;
  logic [EV_W-1:0]    next_events;
  logic               hit_plain;
  logic [PLAIN_W-1:0] plain_idx;
  logic               hit_target;
  logic               hit_misc;
  logic               hit_status;
  logic               hit_enable;
  logic               hit_clear;
  logic               mapped;
  logic               target_load;
  logic               target_refused;
  logic               bad_access;
  logic               split_fault;
  logic               split_issue;

  // Address decode.
  always_comb
  begin
    hit_plain = 1'b0;
    plain_idx = '0;
    case (BUS_REQ.addr)
      OFS_PERF_STATE_REQUEST:
      begin
        hit_plain = 1'b1;
        plain_idx = 2'h0;
      end
      OFS_CLOCK_DUTY_THROTTLE:
      begin
        hit_plain = 1'b1;
        plain_idx = 2'h1;
      end
      OFS_THERMAL_IRQ_CTRL:
      begin
        hit_plain = 1'b1;
        plain_idx = 2'h2;
      end
      OFS_THERMAL_MON_STATE:
      begin
        hit_plain = 1'b1;
        plain_idx = 2'h3;
      end
      default:
      begin
        hit_plain = 1'b0;
        plain_idx = '0;
      end
    endcase
  end

  assign hit_target = (BUS_REQ.addr == OFS_SECOND_STAGE_TARGET);
  assign hit_misc   = (BUS_REQ.addr == OFS_MISC_FEATURE_SW);
  assign hit_status = (BUS_REQ.addr == OFS_EVENT_STATUS);
  assign hit_enable = (BUS_REQ.addr == OFS_EVENT_ENABLE);
  assign hit_clear  = (BUS_REQ.addr == OFS_EVENT_CLEAR);
  assign mapped     = hit_plain | hit_target | hit_misc | hit_status |
                      hit_enable | hit_clear;

  // Only the model 3 variant accepts a new target; every other variant keeps
  // the old one and faults the write instead.
  assign target_load    = BUS_REQ.wr & hit_target &
                          (MODEL == MODEL_LOADS_TARGET);
  assign target_refused = BUS_REQ.wr & hit_target &
                          (MODEL != MODEL_LOADS_TARGET);

  // An access to an unmapped index faults like any unknown register would.
  assign bad_access = ((BUS_REQ.wr | BUS_REQ.rd) & ~mapped) | target_refused;

  // Locked access handling.
  assign split_fault = LOCK_IN.req & LOCK_IN.split &
                       misc[SPLIT_LOCK_DISABLE_BIT];
  assign split_issue = LOCK_IN.req & LOCK_IN.split &
                       ~misc[SPLIT_LOCK_DISABLE_BIT];

  // Plain storage registers.
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      for (int i = 0; i < PLAIN_N; i++)
      begin
        plain_reg[i] <= PLAIN_RESET;
      end
    end
    else if (BUS_REQ.wr && hit_plain)
    begin
      plain_reg[plain_idx] <= BUS_REQ.wdata;
    end
  end

  // Second-stage thermal target.
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      target <= TARGET_RESET;
    end
    else if (target_load)
    begin
      target <= BUS_REQ.wdata;
    end
  end

  assign THROTTLE_TARGET = target;

  // Feature switches; reserved positions never store a one.
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      misc <= MISC_RESET;
    end
    else if (BUS_REQ.wr && hit_misc)
    begin
      misc <= BUS_REQ.wdata & MISC_WRITE_MASK;
    end
  end

  assign FEATURE_SWITCHES = misc;

  // Read data, valid in the cycle after the read strobe only.
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      RDATA <= '0;
    end
    else if (!BUS_REQ.rd)
    begin
      RDATA <= '0;
    end
    else if (hit_plain)
    begin
      RDATA <= plain_reg[plain_idx];
    end
    else if (hit_target)
    begin
      RDATA <= target;
    end
    else if (hit_misc)
    begin
      RDATA <= misc & MISC_WRITE_MASK;
    end
    else if (hit_status)
    begin
      RDATA <= {{(DATA_W-EV_W){1'b0}}, ev_status};
    end
    else if (hit_enable)
    begin
      RDATA <= {{(DATA_W-EV_W){1'b0}}, ev_enable};
    end
    else
    begin
      RDATA <= '0;
    end
  end

  // Protection fault pulse, one cycle after the offending access.
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      GP_FAULT <= 1'b0;
    end
    else
    begin
      GP_FAULT <= bad_access;
    end
  end

  // Locked access answer, one cycle after the request.
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      LOCK_OUT <= '0;
    end
    else
    begin
      LOCK_OUT.align_fault <= split_fault;
      LOCK_OUT.split_cycle <= split_issue;
      LOCK_OUT.plain_cycle <= LOCK_IN.req & ~LOCK_IN.split;
    end
  end

  // Event collection.
  always_comb
  begin
    next_events = '0;
    next_events[EV_ALIGN_FAULT] = split_fault;
    next_events[EV_GP_FAULT]    = bad_access;
    next_events[EV_SPLIT_LOCK]  = split_issue;
    next_events[EV_TARGET_LOAD] = target_load;
  end

  // Sticky status. A new event in the clearing cycle survives the clear,
  // so software never loses an event it has not yet seen.
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ev_status <= EV_RESET;
    end
    else if (BUS_REQ.wr && hit_clear)
    begin
      ev_status <= (ev_status & ~BUS_REQ.wdata[EV_W-1:0]) | next_events;
    end
    else
    begin
      ev_status <= ev_status | next_events;
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ev_enable <= EV_RESET;
    end
    else if (BUS_REQ.wr && hit_enable)
    begin
      ev_enable <= BUS_REQ.wdata[EV_W-1:0];
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      IRQ <= 1'b0;
    end
    else
    begin
      IRQ <= |(ev_status & ev_enable);
    end
  end

endmodule

// ---- test/thermal_feature_checker.sv ----
// Port checks for the thermal and feature register bank.
`timescale 1ns/1ns
module thermal_feature_checker
  import thermal_feature_pkg::*;
#(
  parameter int MODEL = 3
)
(
  input wire logic                                CLK,
  input wire logic                                RESET,
  input wire thermal_feature_pkg::reg_req_t       BUS_REQ,
  input wire logic [thermal_feature_pkg::DATA_W-1:0] RDATA,
  input wire logic                                GP_FAULT,
  input wire thermal_feature_pkg::lock_req_t      LOCK_IN,
  input wire thermal_feature_pkg::lock_ans_t      LOCK_OUT,
  input wire logic [thermal_feature_pkg::DATA_W-1:0] THROTTLE_TARGET,
  input wire logic [thermal_feature_pkg::DATA_W-1:0] FEATURE_SWITCHES,
  input wire logic                                IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  wire tgt_wr = BUS_REQ.wr && BUS_REQ.addr == OFS_SECOND_STAGE_TARGET;
  wire tgt_rd = BUS_REQ.rd && BUS_REQ.addr == OFS_SECOND_STAGE_TARGET;
  wire sw_wr = BUS_REQ.wr && BUS_REQ.addr == OFS_MISC_FEATURE_SW;
  wire slock = LOCK_IN.req && LOCK_IN.split;
  wire noac = !FEATURE_SWITCHES[SPLIT_LOCK_DISABLE_BIT];
  AST_TARGET_LOAD: assert property (MODEL == 3 && tgt_wr |=>
    THROTTLE_TARGET == $past(BUS_REQ.wdata)) else $error("target load");
  AST_TARGET_READ: assert property (tgt_rd |=>
    RDATA == THROTTLE_TARGET) else $error("target read");
  AST_TARGET_REFUSE: assert property (MODEL != 3 && tgt_wr |=>
    GP_FAULT && $stable(THROTTLE_TARGET)) else $error("target refuse");
  AST_SPLIT_FAULT: assert property (slock && !noac |=>
    LOCK_OUT == 3'b100) else $error("split fault");
  AST_SPLIT_CYCLE: assert property (slock && noac |=>
    LOCK_OUT == 3'b010) else $error("split cycle");
  AST_RSVD_ZERO: assert property (sw_wr |=>
    FEATURE_SWITCHES == ($past(BUS_REQ.wdata) & MISC_WRITE_MASK))
    else $error("reserved bits");
  AST_PLAIN_CYCLE: assert property (LOCK_IN.req && !LOCK_IN.split |=>
    LOCK_OUT == 3'b001) else $error("plain cycle");
  AST_TARGET_NO_GP: assert property (MODEL == 3 && tgt_wr |=>
    !GP_FAULT) else $error("target write fault");
  AST_RDATA_IDLE: assert property (!BUS_REQ.rd |=>
    RDATA == '0) else $error("read data idle");
endmodule

bind thermal_feature_regs thermal_feature_checker #(.MODEL(MODEL)) chk_i (
  .CLK(CLK), .RESET(RESET), .BUS_REQ(BUS_REQ), .RDATA(RDATA),
  .GP_FAULT(GP_FAULT), .LOCK_IN(LOCK_IN), .LOCK_OUT(LOCK_OUT),
  .THROTTLE_TARGET(THROTTLE_TARGET), .FEATURE_SWITCHES(FEATURE_SWITCHES),
  .IRQ(IRQ));

// ---- test/tb_top.sv ----
// Self-checking bench for the thermal and feature register bank.
`timescale 1ns/1ns
module tb_top;
  import thermal_feature_pkg::*;
  logic        CLK;
  logic        RESET;
  reg_req_t    req;
  lock_req_t   lock;
  lock_ans_t   ans;
  logic [63:0] rdata;
  logic [63:0] thr;
  logic [63:0] thr2;
  logic [63:0] fsw;
  logic        gp;
  logic        gp2;
  logic        irq;
  logic [63:0] d;
  int          fail_count;
  int          tests_run;
  logic [11:0] offs [6] = '{OFS_PERF_STATE_REQUEST, OFS_CLOCK_DUTY_THROTTLE,
    OFS_THERMAL_IRQ_CTRL, OFS_THERMAL_MON_STATE, OFS_SECOND_STAGE_TARGET,
    OFS_MISC_FEATURE_SW};

  thermal_feature_regs #(.MODEL(3)) dut (.CLK(CLK), .RESET(RESET),
    .BUS_REQ(req), .RDATA(rdata), .GP_FAULT(gp), .LOCK_IN(lock),
    .LOCK_OUT(ans), .THROTTLE_TARGET(thr), .FEATURE_SWITCHES(fsw), .IRQ(irq));
  // A model 6 part shares the bus to see target writes refused.
  thermal_feature_regs #(.MODEL(6)) dut2 (.CLK(CLK), .RESET(RESET),
    .BUS_REQ(req), .RDATA(), .GP_FAULT(gp2), .LOCK_IN(lock),
    .LOCK_OUT(), .THROTTLE_TARGET(thr2), .FEATURE_SWITCHES(), .IRQ());

  always #5 CLK = ~CLK;

  task automatic chk(input string n, input logic [63:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // What a read of register i returns after v was written there.
  function automatic logic [63:0] read_back(input int i,
                                            input logic [63:0] v);
    return (offs[i] == OFS_MISC_FEATURE_SW) ? v & MISC_WRITE_MASK : v;
  endfunction

  // Answers stand one cycle only, so they are taken just after that edge.
  task automatic op(input logic [11:0] a, input logic [63:0] wd, e,
                    input logic w, g);
    @(posedge CLK);
    req <= '{a, wd, w, !w};
    @(posedge CLK);
    req <= '0;
    #1;
    if (!w)
      chk("rdata", rdata, e);
    chk("fault", gp, g);
  endtask

  task automatic lk(input logic s, input logic [2:0] e);
    @(posedge CLK);
    lock <= '{1'b1, s};
    @(posedge CLK);
    lock <= '0;
    #1;
    chk("lock", ans, e);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    fail_count++;
    conclude();
  end

  initial
  begin
    CLK = 0;
    RESET = 1;
    req = '0;
    lock = '0;
    fail_count = 0;
    tests_run = 0;
    void'($urandom(60));
    repeat (16) @(posedge CLK);
    RESET <= 0;
    foreach (offs[i])
      op(offs[i], 0, 0, 0, 0);
    foreach (offs[i])
    begin
      d = {$urandom, $urandom};
      op(offs[i], d, 0, 1, 0);
      op(offs[i], 0, read_back(i, d), 0, 0);
    end
    op(12'h0aa, 0, 0, 0, 1);
    @(posedge CLK);
    #1;
    chk("rdata idle", rdata, 0);
    op(12'h0bb, {$urandom, $urandom}, 0, 1, 1);
    op(OFS_SECOND_STAGE_TARGET, 64'h5a, 0, 1, 0);
    chk("gp2", gp2, 1);
    chk("thr2", thr2, 0);
    chk("thr", thr, 64'h5a);
    op(OFS_MISC_FEATURE_SW, '1, 0, 1, 0);
    chk("switches", fsw, MISC_WRITE_MASK);
    op(OFS_MISC_FEATURE_SW, 0, MISC_WRITE_MASK, 0, 0);
    lk(1, 3'b100);
    op(OFS_MISC_FEATURE_SW, 0, 0, 1, 0);
    lk(1, 3'b010);
    lk(0, 3'b001);
    chk("irq", irq, 0);
    op(OFS_EVENT_STATUS, '1, 0, 1, 0);
    op(OFS_EVENT_STATUS, 0, 64'hf, 0, 0);
    op(OFS_EVENT_ENABLE, 1, 0, 1, 0);
    repeat (2) @(posedge CLK);
    #1;
    chk("irq", irq, 1);
    op(OFS_EVENT_CLEAR, 64'hf, 0, 1, 0);
    repeat (2) @(posedge CLK);
    #1;
    chk("irq", irq, 0);
    op(OFS_EVENT_STATUS, 0, 0, 0, 0);
    conclude();
  end
endmodule
